// ---- gps_pkg.sv ----
// constants, register map and state type of the shared data-bus gpio ports
// assumes an axi4-lite master on the system clock and a bus controller outside
// What this block does
// - direction registers are write-only; reading them returns a fixed meaningless value
// - upper port is data bus d15-d8 in modes 1,2,4 and mode 7 expanded
// - output data register drives a pin only when it is a gpio output
// - pin-state read gives data bit when direction is 1, pin level otherwise
// - pin-state register is read-only; writes change nothing; reset shows pins
// - upper pull-up on in mode 7 only when direction 0 and pull-up bit 1
// - upper pull-ups stay off in modes 1, 2 and 4 at all times
// - open-drain bit 1 drives low only on non-bus pins; 0 is push-pull
// - modes 1,2,4: lower port gpio on 8-bit bus, data d7-d0 on 16-bit
// - mode 7 unexpanded lower port is gpio; expanded follows bus width
// - gpio pin with direction 1 is output, with direction 0 is input
// - lower pull-up on only when direction 0, pull-up bit 1, 8-bit bus
// - lower pull-ups off in reset, hardware standby and 16-bit bus mode
package gps_pkg;
    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] UP_DIR_OFF = 8'h00;
    localparam logic [AXI_AW-1:0] UP_DATA_OFF = 8'h04;
    localparam logic [AXI_AW-1:0] UP_PIN_OFF = 8'h08;
    localparam logic [AXI_AW-1:0] UP_PULL_OFF = 8'h0C;
    localparam logic [AXI_AW-1:0] UP_OD_OFF = 8'h10;
    localparam logic [AXI_AW-1:0] LO_DIR_OFF = 8'h14;
    localparam logic [AXI_AW-1:0] LO_DATA_OFF = 8'h18;
    localparam logic [AXI_AW-1:0] LO_PIN_OFF = 8'h1C;
    localparam logic [AXI_AW-1:0] LO_PULL_OFF = 8'h20;
    localparam logic [AXI_AW-1:0] LO_OD_OFF = 8'h24;
    localparam logic [AXI_AW-1:0] STATUS_OFF = 8'h28;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] DIR_READ_VALUE = 8'hFF; // arbitrary filler for write-only reads
    localparam logic [2:0] MODE_SINGLE = 3'h7;
    localparam int STAT_UP_BUS_BIT = 0;
    localparam int STAT_LO_BUS_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] u_dir;
        logic [7:0] u_data;
        logic [7:0] u_pull;
        logic [7:0] u_od;
        logic [7:0] l_dir;
        logic [7:0] l_data;
        logic [7:0] l_pull;
        logic [7:0] l_od;
        logic [7:0] u_sync1;
        logic [7:0] u_sync2;
        logic [7:0] l_sync1;
        logic [7:0] l_sync2;
        logic aw_rdy;
        logic aw_ok;
        logic [AXI_AW-1:0] aw_addr;
        logic w_rdy;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] u_out;
        logic [7:0] u_oe;
        logic [7:0] u_pu;
        logic [7:0] l_out;
        logic [7:0] l_oe;
        logic [7:0] l_pu;
        logic [15:0] bus_din;
        logic u_bus;
        logic l_bus;
    } gps_state_type;
endpackage

// ---- gps_ports.sv ----
// two 8-bit gpio ports sharing pins with the external data bus, axi4-lite slave
// assumes mode straps and bus width come from the system and stay quiet
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module gps_ports import gps_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] mode_sel,
    input wire logic external_expansion_enable,
    input wire logic bus_16bit,
    input wire logic hw_standby,
    input wire logic [15:0] bus_data_out,
    input wire logic bus_data_oe,
    output logic [15:0] bus_data_in,
    input wire logic [7:0] upper_pin_in,
    output logic [7:0] upper_pin_out,
    output logic [7:0] upper_pin_oe,
    output logic [7:0] upper_pullup,
    input wire logic [7:0] lower_pin_in,
    output logic [7:0] lower_pin_out,
    output logic [7:0] lower_pin_oe,
    output logic [7:0] lower_pullup,
    output logic upper_is_bus,
    output logic lower_is_bus
);

    gps_state_type cur_reg;
    gps_state_type cur_next;
    logic u_bus_c;
    logic l_bus_c;
    logic wr_go;
    logic [AXI_AW-1:0] wr_addr;

    // per-bit readback mix of a pin-state register
    function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] dat,
                                            input logic [7:0] lvl);
        pin_view = (dir & dat) | (~dir & lvl);
    endfunction

    // pin driver for one port: {out, oe}
    function automatic logic [15:0] drive(input logic on_bus, input logic [7:0] dir,
                                          input logic [7:0] dat, input logic [7:0] od,
                                          input logic [7:0] bval, input logic boe);
        logic [7:0] o;
        logic [7:0] e;
        o = 8'h00;
        e = 8'h00;
        if (on_bus) begin
            // data bus output is always push-pull
            o = bval;
            e = {8{boe}};
        end else begin
            // open-drain only pulls low, so high means release
            o = dat & ~od;
            e = dir & (~od | ~dat);
        end
        drive = {o, e};
    endfunction

    // single-chip mode test
    function automatic logic is_single(input logic [2:0] m);
        is_single = (m == MODE_SINGLE);
    endfunction

    // register readback, also flags unmapped addresses
    function automatic logic [33:0] rd_word(input gps_state_type s,
                                            input logic [AXI_AW-1:0] a);
        logic [7:0] v;
        logic [1:0] r;
        v = 8'h00;
        r = RESP_OKAY;
        case (a)
            UP_DIR_OFF: v = DIR_READ_VALUE;
            UP_DATA_OFF: v = s.u_data;
            UP_PIN_OFF: v = pin_view(s.u_dir, s.u_data, s.u_sync2);
            UP_PULL_OFF: v = s.u_pull;
            UP_OD_OFF: v = s.u_od;
            LO_DIR_OFF: v = DIR_READ_VALUE;
            LO_DATA_OFF: v = s.l_data;
            LO_PIN_OFF: v = pin_view(s.l_dir, s.l_data, s.l_sync2);
            LO_PULL_OFF: v = s.l_pull;
            LO_OD_OFF: v = s.l_od;
            STATUS_OFF: begin
                v[STAT_UP_BUS_BIT] = s.u_bus;
                v[STAT_LO_BUS_BIT] = s.l_bus;
            end
            default: r = RESP_SLVERR;
        endcase
        rd_word = {r, 24'h00_0000, v};
    endfunction

    // bus ownership of each port from mode, expansion and bus width
    always_comb begin
        u_bus_c = !is_single(mode_sel) || external_expansion_enable;
        l_bus_c = u_bus_c && bus_16bit;
    end

    // next-state logic of the whole block
    always_comb begin
        logic [15:0] ud;
        logic [15:0] ld;
        logic [33:0] rw;
        cur_next = cur_reg;
        ud = 16'h0000;
        ld = 16'h0000;
        rw = 34'h0_0000_0000;
        wr_go = 1'b0;
        wr_addr = cur_reg.aw_addr;

        // two-flop synchronisers, first stage feeds only the second
        cur_next.u_sync1 = upper_pin_in;
        cur_next.u_sync2 = cur_reg.u_sync1;
        cur_next.l_sync1 = lower_pin_in;
        cur_next.l_sync2 = cur_reg.l_sync1;

        // write address and data captured in either order
        if (s_axi_awvalid && cur_reg.aw_rdy) begin
            cur_next.aw_ok = 1'b1;
            cur_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && cur_reg.w_rdy) begin
            cur_next.w_ok = 1'b1;
            cur_next.w_data = s_axi_wdata;
            cur_next.w_strb = s_axi_wstrb;
        end
        if (cur_reg.bvalid && s_axi_bready) begin
            cur_next.bvalid = 1'b0;
        end

        // commit once both halves are held; only lane 0 carries data
        wr_addr = cur_next.aw_addr;
        wr_go = cur_next.aw_ok && cur_next.w_ok && !cur_reg.bvalid;
        if (wr_go) begin
            cur_next.aw_ok = 1'b0;
            cur_next.w_ok = 1'b0;
            cur_next.bvalid = 1'b1;
            cur_next.bresp = RESP_OKAY;
            if (cur_next.w_strb[0]) begin
                case (wr_addr)
                    UP_DIR_OFF: cur_next.u_dir = cur_next.w_data[7:0];
                    UP_DATA_OFF: cur_next.u_data = cur_next.w_data[7:0];
                    UP_PULL_OFF: cur_next.u_pull = cur_next.w_data[7:0];
                    UP_OD_OFF: cur_next.u_od = cur_next.w_data[7:0];
                    LO_DIR_OFF: cur_next.l_dir = cur_next.w_data[7:0];
                    LO_DATA_OFF: cur_next.l_data = cur_next.w_data[7:0];
                    LO_PULL_OFF: cur_next.l_pull = cur_next.w_data[7:0];
                    LO_OD_OFF: cur_next.l_od = cur_next.w_data[7:0];
                    default: ; // pin-state and status ignore writes
                endcase
            end
            rw = rd_word(cur_reg, wr_addr);
            if (rw[33:32] == RESP_SLVERR) begin
                cur_next.bresp = RESP_SLVERR;
            end
        end

        // read channel, answer one cycle after the address
        if (cur_reg.rvalid && s_axi_rready) begin
            cur_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && cur_reg.ar_rdy) begin
            rw = rd_word(cur_reg, s_axi_araddr);
            cur_next.rvalid = 1'b1;
            cur_next.rdata = rw[31:0];
            cur_next.rresp = rw[33:32];
        end
        cur_next.aw_rdy = !cur_next.aw_ok && !cur_next.bvalid;
        cur_next.w_rdy = !cur_next.w_ok && !cur_next.bvalid;
        cur_next.ar_rdy = !cur_next.rvalid;

        // pin drivers act on the current register copy
        ud = drive(u_bus_c, cur_reg.u_dir, cur_reg.u_data, cur_reg.u_od,
                   bus_data_out[15:8], bus_data_oe);
        ld = drive(l_bus_c, cur_reg.l_dir, cur_reg.l_data, cur_reg.l_od,
                   bus_data_out[7:0], bus_data_oe);
        cur_next.u_out = ud[15:8];
        cur_next.u_oe = ud[7:0];
        cur_next.l_out = ld[15:8];
        cur_next.l_oe = ld[7:0];
        cur_next.u_bus = u_bus_c;
        cur_next.l_bus = l_bus_c;

        // pull-ups; software standby leaves them under control
        cur_next.u_pu = 8'h00;
        if (is_single(mode_sel) && !hw_standby) begin
            cur_next.u_pu = ~cur_reg.u_dir & cur_reg.u_pull;
        end
        cur_next.l_pu = 8'h00;
        if (!bus_16bit && !hw_standby) begin
            cur_next.l_pu = ~cur_reg.l_dir & cur_reg.l_pull;
        end

        // data returned to the bus controller, read from synchronised pins
        cur_next.bus_din = {cur_reg.u_sync2, cur_reg.l_sync2};
    end

    // state register; reset leaves pull-ups and drivers off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // every output straight from the state register
    always_comb begin
        s_axi_awready = cur_reg.aw_rdy;
        s_axi_wready = cur_reg.w_rdy;
        s_axi_bresp = cur_reg.bresp;
        s_axi_bvalid = cur_reg.bvalid;
        s_axi_arready = cur_reg.ar_rdy;
        s_axi_rdata = cur_reg.rdata;
        s_axi_rresp = cur_reg.rresp;
        s_axi_rvalid = cur_reg.rvalid;
        bus_data_in = cur_reg.bus_din;
        upper_pin_out = cur_reg.u_out;
        upper_pin_oe = cur_reg.u_oe;
        upper_pullup = cur_reg.u_pu;
        lower_pin_out = cur_reg.l_out;
        lower_pin_oe = cur_reg.l_oe;
        lower_pullup = cur_reg.l_pu;
        upper_is_bus = cur_reg.u_bus;
        lower_is_bus = cur_reg.l_bus;
    end

    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // direction reads hide the stored bits
    property p_dir_read_hidden;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == UP_DIR_OFF)
            |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, DIR_READ_VALUE};
    endproperty
    a_dir_read_hidden: assert property (p_dir_read_hidden)
        else $error("direction read leaked stored bits");

    property p_upper_bus_mode;
        (!is_single(mode_sel) || external_expansion_enable) |=> upper_is_bus;
    endproperty
    a_upper_bus_mode: assert property (p_upper_bus_mode)
        else $error("upper port not on data bus");

    property p_upper_gpio_drive;
        (!u_bus_c && cur_reg.u_dir[0] && !cur_reg.u_od[0])
            |=> upper_pin_oe[0] && upper_pin_out[0] == $past(cur_reg.u_data[0]);
    endproperty
    a_upper_gpio_drive: assert property (p_upper_gpio_drive)
        else $error("gpio output does not drive stored value");

    property p_pin_view;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == LO_PIN_OFF)
            |=> s_axi_rdata[7:0] == $past(pin_view(cur_reg.l_dir, cur_reg.l_data,
                                                    cur_reg.l_sync2));
    endproperty
    a_pin_view: assert property (p_pin_view)
        else $error("pin-state read mixed wrongly");

    property p_pin_state_ro;
        (wr_go && wr_addr == UP_PIN_OFF) |=> $stable(cur_reg.u_data) && $stable(cur_reg.u_dir)
            && s_axi_bvalid && s_axi_bresp == RESP_OKAY;
    endproperty
    a_pin_state_ro: assert property (p_pin_state_ro)
        else $error("pin-state write had an effect");

    property p_upper_pull_on;
        (is_single(mode_sel) && !hw_standby && !cur_reg.u_dir[7] && cur_reg.u_pull[7])
            |=> upper_pullup[7];
    endproperty
    a_upper_pull_on: assert property (p_upper_pull_on)
        else $error("upper pull-up missing");

    property p_upper_pull_off;
        !is_single(mode_sel) |=> upper_pullup == 8'h00;
    endproperty
    a_upper_pull_off: assert property (p_upper_pull_off)
        else $error("upper pull-up on outside single-chip mode");

    property p_open_drain;
        (!u_bus_c && cur_reg.u_dir[1] && cur_reg.u_od[1])
            |=> !upper_pin_out[1] && upper_pin_oe[1] == !$past(cur_reg.u_data[1]);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin drove high");

    property p_lower_width;
        !is_single(mode_sel) |=> lower_is_bus == $past(bus_16bit);
    endproperty
    a_lower_width: assert property (p_lower_width)
        else $error("lower port ignores bus width");

    property p_lower_single;
        (is_single(mode_sel) && !external_expansion_enable) |=> !lower_is_bus;
    endproperty
    a_lower_single: assert property (p_lower_single)
        else $error("lower port on bus in single-chip mode");

    property p_input_floats;
        (!l_bus_c && !cur_reg.l_dir[2]) |=> !lower_pin_oe[2];
    endproperty
    a_input_floats: assert property (p_input_floats)
        else $error("input pin is driven");

    property p_lower_pull;
        (bus_16bit || hw_standby) |=> lower_pullup == 8'h00;
    endproperty
    a_lower_pull: assert property (p_lower_pull)
        else $error("lower pull-up on when it must be off");

    // input pins of an 8-bit bus lower port keep their pull-up
    property p_lower_pull_on;
        (!bus_16bit && !hw_standby && !cur_reg.l_dir[1] && cur_reg.l_pull[1])
            |=> lower_pullup[1];
    endproperty
    a_lower_pull_on: assert property (p_lower_pull_on)
        else $error("lower pull-up missing");

    // hardware standby drops the upper pull-ups in every mode
    property p_upper_pull_standby;
        hw_standby |=> upper_pullup == 8'h00;
    endproperty
    a_upper_pull_standby: assert property (p_upper_pull_standby)
        else $error("upper pull-up on in hardware standby");

    property p_lo_dir_hidden;
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == LO_DIR_OFF)
            |=> s_axi_rvalid && s_axi_rdata[7:0] == DIR_READ_VALUE;
    endproperty
    a_lo_dir_hidden: assert property (p_lo_dir_hidden)
        else $error("lower direction read leaked stored bits");

    // a committed write is in the register one edge later
    property p_write_commit;
        (wr_go && wr_addr == UP_DATA_OFF && cur_next.w_strb[0])
            |=> cur_reg.u_data == $past(cur_next.w_data[7:0]);
    endproperty
    a_write_commit: assert property (p_write_commit)
        else $error("register write did not land on the next edge");

    // bus mode: controller data and enable pass through, open-drain ignored
    property p_upper_bus_drive;
        u_bus_c |=> upper_pin_out == $past(bus_data_out[15:8])
            && upper_pin_oe == {8{$past(bus_data_oe)}};
    endproperty
    a_upper_bus_drive: assert property (p_upper_bus_drive)
        else $error("upper port does not carry bus data");

    property p_lower_bus_drive;
        l_bus_c |=> lower_pin_out == $past(bus_data_out[7:0])
            && lower_pin_oe == {8{$past(bus_data_oe)}};
    endproperty
    a_lower_bus_drive: assert property (p_lower_bus_drive)
        else $error("lower port does not carry bus data");

    property p_sync_path;
        1'b1 ##2 $stable(upper_pin_in) [*3] |=> bus_data_in[15:8] == $past(upper_pin_in, 2);
    endproperty
    a_sync_path: assert property (p_sync_path)
        else $error("pin level not passed through two flops");

    c_upper_bus: cover property (u_bus_c ##1 upper_is_bus && upper_pin_oe == 8'hFF);
    c_lower_gpio_out: cover property (!l_bus_c && cur_reg.l_dir != 8'h00 ##1 lower_pin_oe != 8'h00);
    c_pin_read: cover property (s_axi_arvalid && s_axi_arready && s_axi_araddr == UP_PIN_OFF);
    c_open_drain: cover property (!u_bus_c && (cur_reg.u_od & cur_reg.u_dir) != 8'h00);
    c_lower_pull: cover property (!bus_16bit && lower_pullup != 8'h00);

endmodule // gps_ports

// ---- gps_bus_model.sv ----
// far-side model: external bus controller data lines and pin level resolution
// assumes bench requests change just after a rising edge of clk
`timescale 1ns/10ps
module gps_bus_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] drv_data,
    input wire logic drv_en,
    input wire logic [15:0] ext_data,
    input wire logic [15:0] ext_en,
    input wire logic [7:0] upper_pin_out,
    input wire logic [7:0] upper_pin_oe,
    input wire logic [7:0] upper_pullup,
    input wire logic [7:0] lower_pin_out,
    input wire logic [7:0] lower_pin_oe,
    input wire logic [7:0] lower_pullup,
    output logic [15:0] bus_data_out,
    output logic bus_data_oe,
    output logic [15:0] pin_level
);
    logic [15:0] junk_reg;
    logic [15:0] oe;
    logic [15:0] out;
    logic [15:0] pu;
    // released data flips each cycle so a stale value can never pass for a match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_data_out <= 16'h0000;
            bus_data_oe <= 1'b0;
            junk_reg <= 16'h5A5A;
        end else begin
            bus_data_oe <= drv_en;
            bus_data_out <= drv_en ? drv_data : ~bus_data_out;
            junk_reg <= ~junk_reg;
        end
    end
    // device drive wins, then outside drivers, then pull-up, else a floating pattern
    assign oe = {upper_pin_oe, lower_pin_oe};
    assign out = {upper_pin_out, lower_pin_out};
    assign pu = {upper_pullup, lower_pullup};
    assign pin_level = (oe & out) | (~oe & ext_en & ext_data) | (~oe & ~ext_en & (pu | junk_reg));
endmodule // gps_bus_model

// ---- gps_ports_tb_top.sv ----
// self-checking bench for the shared data-bus gpio ports over axi4-lite
// assumes gps_bus_model resolves every pin level and drives controller data
`timescale 1ns/10ps
module gps_ports_tb_top import gps_pkg::*; ;
    logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] mode_sel;
    logic external_expansion_enable, bus_16bit, hw_standby, bus_data_oe, drv_en, xp;
    logic upper_is_bus, lower_is_bus;
    logic [15:0] bus_data_out, bus_data_in, drv_data, ext_data, ext_en, pins;
    logic [7:0] upper_pin_in, upper_pin_out, upper_pin_oe, upper_pullup;
    logic [7:0] lower_pin_in, lower_pin_out, lower_pin_oe, lower_pullup;
    logic [7:0] zero_offs [6] = '{UP_DATA_OFF, UP_PULL_OFF, UP_OD_OFF, LO_DATA_OFF, LO_PULL_OFF,
        LO_OD_OFF};
    logic [2:0] modes [4] = '{3'h1, 3'h2, 3'h4, MODE_SINGLE};
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    gps_ports u_dut (
        .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .mode_sel, .external_expansion_enable, .bus_16bit, .hw_standby, .bus_data_out,
        .bus_data_oe, .bus_data_in, .upper_pin_in, .upper_pin_out, .upper_pin_oe, .upper_pullup,
        .lower_pin_in, .lower_pin_out, .lower_pin_oe, .lower_pullup, .upper_is_bus, .lower_is_bus
    );
    gps_bus_model u_far (
        .clk, .rst_n, .drv_data, .drv_en, .ext_data, .ext_en, .upper_pin_out, .upper_pin_oe,
        .upper_pullup, .lower_pin_out, .lower_pin_oe, .lower_pullup, .bus_data_out,
        .bus_data_oe, .pin_level(pins)
    );
    assign upper_pin_in = pins[15:8];
    assign lower_pin_in = pins[7:0];

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // bready stays high, so only address and data valids move here
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rsp);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(rsp));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(32'(s_axi_rresp), 32'(RESP_OKAY));
        chk(s_axi_rdata, exp);
    endtask

    // covers one write commit plus two synchroniser stages
    task automatic settle();
        repeat (4) @(posedge clk);
    endtask

    initial begin
        rst_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, drv_en, hw_standby} = '0;
        {external_expansion_enable, bus_16bit, s_axi_bready, s_axi_rready} = 4'b0011;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'h1;
        mode_sel = MODE_SINGLE;
        drv_data = 16'h0000;
        ext_data = 16'hA55A;
        ext_en = 16'hFFFF;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        // refused and read-only places, then reset contents
        wr(8'h2C, 8'h11, RESP_SLVERR);
        wr(UP_PIN_OFF, 8'hFF, RESP_OKAY);
        rd(UP_PIN_OFF, 32'h0000_00A5);
        rd(LO_PIN_OFF, 32'h0000_005A);
        rd(UP_DIR_OFF, 32'(DIR_READ_VALUE));
        rd(LO_DIR_OFF, 32'(DIR_READ_VALUE));
        foreach (zero_offs[i])
            rd(zero_offs[i], 32'h0000_0000);
        $display("test registers done");
        // gpio outputs on the low nibble, outside drivers on the high nibble
        ext_en <= 16'hF0FF;
        wr(UP_DIR_OFF, 8'h0F, RESP_OKAY);
        wr(UP_DATA_OFF, 8'h3C, RESP_OKAY);
        settle();
        chk(32'(upper_pin_oe), 32'h0000_000F);
        chk(32'(upper_pin_out & 8'h0F), 32'h0000_000C);
        rd(UP_PIN_OFF, 32'h0000_00AC);
        wr(UP_OD_OFF, 8'h0F, RESP_OKAY);
        settle();
        chk(32'(upper_pin_oe), 32'h0000_0003);
        chk(32'(upper_pin_out & upper_pin_oe), 32'h0000_0000);
        rd(UP_PIN_OFF, 32'h0000_00AC);
        $display("test gpio done");
        // pull-ups follow direction, control bit, mode, width and standby
        ext_en <= 16'h0000;
        wr(UP_PULL_OFF, 8'hFF, RESP_OKAY);
        wr(LO_PULL_OFF, 8'hAA, RESP_OKAY);
        hw_standby <= 1'b1;
        settle();
        chk(32'({upper_pullup, lower_pullup}), 32'h0000_0000);
        hw_standby <= 1'b0;
        foreach (modes[m]) begin
            mode_sel <= modes[m];
            settle();
            chk(32'(upper_pullup), (modes[m] == MODE_SINGLE) ? 32'h0000_00F0 : 32'h0);
            chk(32'(lower_pullup), 32'h0000_00AA);
        end
        bus_16bit <= 1'b1;
        settle();
        chk(32'(lower_pullup), 32'h0000_0000);
        $display("test pullup done");
        // every mode, expansion and width combination
        foreach (modes[m])
            for (int k = 0; k < 4; k++) begin
                mode_sel <= modes[m];
                external_expansion_enable <= k[1];
                bus_16bit <= k[0];
                settle();
                xp = (modes[m] != MODE_SINGLE) || k[1];
                chk(32'({upper_is_bus, lower_is_bus}), 32'({xp, xp & k[0]}));
            end
        // bus mode hands both ports to the controller, open-drain ignored
        mode_sel <= 3'h1;
        bus_16bit <= 1'b1;
        drv_en <= 1'b1;
        drv_data <= 16'h1234;
        settle();
        chk(32'({upper_pin_oe, lower_pin_oe}), 32'h0000_FFFF);
        chk(32'({upper_pin_out, lower_pin_out}), 32'h0000_1234);
        // model register and pin drive take two edges, the sync path three more
        repeat (2) @(posedge clk);
        chk(32'(bus_data_in), 32'h0000_1234);
        rd(STATUS_OFF, (32'h1 << STAT_UP_BUS_BIT) | (32'h1 << STAT_LO_BUS_BIT));
        bus_16bit <= 1'b0;
        settle();
        chk(32'({upper_pin_oe, lower_pin_oe}), 32'h0000_FF00);
        chk(32'(lower_pullup), 32'h0000_00AA);
        $display("test bus done");
        end_sim();
    end
endmodule // gps_ports_tb_top
